// file: pps_pkg.sv
// Package for the pressure control path: constants, modes and config carriers.
// Assumes one 125 MHz system clock; all values are in the units noted beside them.
package pps_pkg;

    timeunit 1ns;
    timeprecision 1ps;

    // Clock and sample timing
    localparam int CLK_KHZ = 125000;
    localparam int SAMPLE_TIME_US = 1000;
    localparam int SAMPLE_CYCLES = CLK_KHZ * SAMPLE_TIME_US / 1000;

    // Full scale in 0.01 % units and internal fixed point
    localparam int FULL_SCALE = 10000;
    localparam int RATIO_ONE = 1000;
    localparam int ACC_SCALE = 1000;
    localparam int RAMP_SPAN = FULL_SCALE * ACC_SCALE * (SAMPLE_TIME_US / 1000);
    localparam int INT_LIMIT = FULL_SCALE * ACC_SCALE;
    localparam int SAMPLE_TENTHS_MS = SAMPLE_TIME_US / 100;

    // Output signal ranges
    localparam int VOLT_FS_MV = 10000;
    localparam int CUR_ZERO_UA = 12000;
    localparam int CUR_SPAN_UA = 8000;
    localparam int CUR_FAULT_UA = 0;
    localparam int CUR_MIN_UA = 4000;

    // Reset values of the working state
    localparam logic [31:0] RESET_ZERO = 32'h0000_0000;

    // Output signal selection
    typedef enum logic [1:0] {
        PPS_VOLT_NORMAL,
        PPS_CUR_NORMAL,
        PPS_VOLT_INVERT,
        PPS_CUR_INVERT
    } pps_out_sel_t;

    // One PID parameter set
    typedef struct packed {
        logic [15:0] gain_p;
        logic [15:0] integral_time;
        logic [15:0] derivative_time;
        logic [15:0] derivative_filter_time;
        logic [15:0] integrator_activation_threshold;
    } pps_pid_set_t;

    // Per direction output adaptation
    typedef struct packed {
        logic [15:0] deadband_min;
        logic [15:0] scale_max;
    } pps_dir_adapt_t;

    // Static configuration of the path
    typedef struct packed {
        logic [15:0] system_pressure_scale;
        logic [15:0] cylinder_area_ratio;
        logic signed [31:0] feedback_offset;
        logic [31:0] pressure_ramp_time_up;
        logic [31:0] pressure_ramp_time_down;
        pps_dir_adapt_t adapt_a;
        pps_dir_adapt_t adapt_b;
        logic [15:0] trigger;
        logic signed [15:0] zero_offset;
        pps_out_sel_t out_sel;
    } pps_cfg_t;

endpackage

// file: pps_pressure_ctrl.sv
// Pressure control path: demand ramp, two-set PID, valve output adaptation.
// Assumes config is quasi static and sensor/demand words are on sys_clk.
module pps_pressure_ctrl #(
    parameter int SAMPLE_CYCLES = pps_pkg::SAMPLE_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Configuration
    input wire pps_pkg::pps_cfg_t cfg,
    input wire pps_pkg::pps_pid_set_t pid_set_1,
    input wire pps_pkg::pps_pid_set_t pid_set_2,
    input wire logic pid_set_select,
    // Control pins and demand
    input wire logic enable_pin,
    input wire logic fault,
    input wire logic signed [31:0] pressure_demand,
    input wire logic signed [31:0] pressure_feedback_mbar,
    // Valve drive
    output logic signed [15:0] drive_mv,
    output logic [15:0] drive_ua,
    output logic current_mode,
    output logic active,
    output logic signed [31:0] valve_out,
    output logic signed [31:0] ramp_cmd
);

    // Time base shared with the bench modules
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////////
    // Kinked characteristic for one direction, magnitude in 0.01 %
    function automatic logic signed [31:0] knee(input logic signed [31:0] mag,
                                               input logic signed [31:0] trig,
                                               input logic signed [31:0] dmin,
                                               input logic signed [31:0] smax);
        logic signed [63:0] prod;
        prod = 64'sd0;
        if (mag == 32'sd0)
        begin
            knee = 32'sd0;
        end
        else if (trig != 32'sd0 && mag < trig)
        begin
            prod = 64'(mag) * 64'(trig + dmin);
            knee = 32'(prod / 64'(trig));
        end
        else
        begin
            prod = 64'(mag - trig) * 64'(smax - trig - dmin);
            knee = trig + dmin + 32'(prod / 64'(pps_pkg::FULL_SCALE - trig));
        end
    endfunction

    function automatic logic signed [31:0] clamp(input logic signed [31:0] v,
                                                input logic signed [31:0] lo,
                                                input logic signed [31:0] hi);
        clamp = (v > hi) ? hi : ((v < lo) ? lo : v);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Enable pin synchroniser, change accepted when stages two and three agree
    logic en_s1, en_s2, en_s3, en_ok;
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            en_s1 <= 1'b0;
            en_s2 <= 1'b0;
            en_s3 <= 1'b0;
            en_ok <= 1'b0;
        end
        else
        begin
            en_s1 <= enable_pin;
            en_s2 <= en_s1;
            en_s3 <= en_s2;
            if (en_s2 == en_s3)
                en_ok <= en_s3;
        end
    end

    // Sample enable divider
    logic [31:0] div_cnt;
    wire sample_en = (div_cnt == 32'(SAMPLE_CYCLES - 1));
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            div_cnt <= pps_pkg::RESET_ZERO;
        else
            div_cnt <= sample_en ? pps_pkg::RESET_ZERO : div_cnt + 32'd1;
    end

    wire run = en_ok && !fault;

    ////////////////////////////////////////////////////////////////////////////
    // Feedback: offset then scale to 0.01 % of system pressure
    wire signed [31:0] scale_bar = 32'(cfg.system_pressure_scale);
    wire signed [63:0] fb_sum = 64'(pressure_feedback_mbar) + 64'(cfg.feedback_offset);
    wire signed [31:0] fb_pct = 32'(fb_sum * 64'sd10 / 64'(scale_bar));

    // Demand ramp in 0.00001 % steps
    logic signed [31:0] ramp_acc;
    wire signed [31:0] ramp_target = clamp(pressure_demand, 32'sd0, 32'(pps_pkg::FULL_SCALE));
    wire signed [31:0] target_acc = ramp_target * 32'(pps_pkg::ACC_SCALE);
    wire signed [31:0] step_up = 32'(pps_pkg::RAMP_SPAN) / 32'(cfg.pressure_ramp_time_up);
    wire signed [31:0] step_dn = 32'(pps_pkg::RAMP_SPAN) / 32'(cfg.pressure_ramp_time_down);
    wire signed [31:0] next_ramp_acc = (target_acc > ramp_acc) ?
        ((target_acc - ramp_acc > step_up) ? ramp_acc + step_up : target_acc) :
        ((ramp_acc - target_acc > step_dn) ? ramp_acc - step_dn : target_acc);

    ////////////////////////////////////////////////////////////////////////////
    // PID with selectable parameter set
    pps_pkg::pps_pid_set_t ps;
    assign ps = pid_set_select ? pid_set_2 : pid_set_1;
    wire signed [31:0] kp = 32'(ps.gain_p);
    wire signed [31:0] ti = 32'(ps.integral_time);
    wire signed [31:0] td = 32'(ps.derivative_time);
    wire signed [31:0] tf = 32'(ps.derivative_filter_time);
    wire signed [31:0] i_thr = 32'(ps.integrator_activation_threshold);

    logic signed [31:0] integ, dfilt, err_prev;
    wire signed [31:0] err = ramp_acc / 32'(pps_pkg::ACC_SCALE) - fb_pct;
    wire signed [63:0] p_term = 64'(kp) * 64'(err) / 64'sd100;
    wire int_on = (ti != 32'sd0) && (fb_pct > i_thr);
    wire signed [63:0] i_inc = (ti == 32'sd0) ? 64'sd0 :
        64'(kp) * 64'(err) * 64'sd100 / 64'(ti);
    wire signed [63:0] i_sum = 64'(integ) + i_inc;
    wire signed [31:0] next_integ = (ti == 32'sd0) ? 32'sd0 :
        (!int_on ? integ : 32'(i_sum > 64'(pps_pkg::INT_LIMIT) ? 64'(pps_pkg::INT_LIMIT) :
        (i_sum < -64'(pps_pkg::INT_LIMIT) ? -64'(pps_pkg::INT_LIMIT) : i_sum)));
    wire signed [63:0] d_raw = 64'(kp) * 64'(td) * 64'(err - err_prev) / 64'sd1000;
    wire signed [63:0] d_step = (d_raw - 64'(dfilt)) * 64'(pps_pkg::SAMPLE_TENTHS_MS) /
        64'(tf + 32'(pps_pkg::SAMPLE_TENTHS_MS));
    wire signed [31:0] next_dfilt = 32'(64'(dfilt) + d_step);
    wire signed [63:0] u_sum = p_term + 64'(integ / 32'(pps_pkg::ACC_SCALE)) + 64'(dfilt);

    // Direction limits from area ratio
    wire signed [31:0] ratio = 32'(cfg.cylinder_area_ratio);
    wire signed [31:0] fs = 32'(pps_pkg::FULL_SCALE);
    wire signed [31:0] lim_a = (ratio >= 32'(pps_pkg::RATIO_ONE)) ? fs :
        fs * ratio / 32'(pps_pkg::RATIO_ONE);
    wire signed [31:0] lim_b = (ratio <= 32'(pps_pkg::RATIO_ONE)) ? fs :
        fs * 32'(pps_pkg::RATIO_ONE) / ratio;
    wire signed [31:0] u_pid = 32'(u_sum > 64'(lim_a) ? 64'(lim_a) :
        (u_sum < -64'(lim_b) ? -64'(lim_b) : u_sum));

    ////////////////////////////////////////////////////////////////////////////
    // Output adaptation, zero correction and saturation
    wire u_neg = u_pid < 32'sd0;
    wire signed [31:0] u_mag = u_neg ? -u_pid : u_pid;
    wire signed [31:0] trig = 32'(cfg.trigger);
    wire signed [31:0] mag_a = knee(u_mag, trig, 32'(cfg.adapt_a.deadband_min),
                                    32'(cfg.adapt_a.scale_max));
    wire signed [31:0] mag_b = knee(u_mag, trig, 32'(cfg.adapt_b.deadband_min),
                                    32'(cfg.adapt_b.scale_max));
    wire signed [31:0] adapted = u_neg ? -mag_b : mag_a;
    wire signed [31:0] with_zero = adapted + 32'(cfg.zero_offset);
    wire signed [31:0] next_valve = run ? clamp(with_zero, -fs, fs) : 32'sd0;

    // Output type and polarity
    wire is_cur = (cfg.out_sel == pps_pkg::PPS_CUR_NORMAL) ||
                  (cfg.out_sel == pps_pkg::PPS_CUR_INVERT);
    wire is_inv = (cfg.out_sel == pps_pkg::PPS_VOLT_INVERT) ||
                  (cfg.out_sel == pps_pkg::PPS_CUR_INVERT);
    wire signed [31:0] pol_val = is_inv ? -next_valve : next_valve;
    wire signed [31:0] next_mv = is_cur ? 32'sd0 : pol_val * 32'(pps_pkg::VOLT_FS_MV) / fs;
    wire signed [31:0] next_ua = !is_cur ? 32'sd0 :
        (!run ? 32'(pps_pkg::CUR_FAULT_UA) :
        32'(pps_pkg::CUR_ZERO_UA) + pol_val * 32'(pps_pkg::CUR_SPAN_UA) / fs);

    ////////////////////////////////////////////////////////////////////////////
    // Sample state update in processing order
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            ramp_acc <= pps_pkg::RESET_ZERO;
            integ <= pps_pkg::RESET_ZERO;
            dfilt <= pps_pkg::RESET_ZERO;
            err_prev <= pps_pkg::RESET_ZERO;
        end
        else if (sample_en)
        begin
            ramp_acc <= run ? next_ramp_acc : pps_pkg::RESET_ZERO;
            integ <= run ? next_integ : pps_pkg::RESET_ZERO;
            dfilt <= run ? next_dfilt : pps_pkg::RESET_ZERO;
            err_prev <= run ? err : pps_pkg::RESET_ZERO;
        end
    end

    // Registered drive outputs
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            valve_out <= pps_pkg::RESET_ZERO;
            drive_mv <= 16'sh0000;
            drive_ua <= 16'h0000;
            current_mode <= 1'b0;
            active <= 1'b0;
        end
        else if (sample_en)
        begin
            valve_out <= next_valve;
            drive_mv <= 16'(next_mv);
            drive_ua <= 16'(next_ua);
            current_mode <= is_cur;
            active <= run;
        end
    end

    assign ramp_cmd = ramp_acc / 32'(pps_pkg::ACC_SCALE);

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    AST_SATURATE: assert property (@(posedge sys_clk) disable iff (reset)
        valve_out <= 32'(pps_pkg::FULL_SCALE) && valve_out >= -32'(pps_pkg::FULL_SCALE))
        else $error("valve output outside full scale");

    AST_CUR_FAULT: assert property (@(posedge sys_clk) disable iff (reset)
        (sample_en && is_cur && !run) |=> (drive_ua == 16'(pps_pkg::CUR_FAULT_UA)))
        else $error("disabled current output not below 4 mA");

    AST_CUR_SPAN: assert property (@(posedge sys_clk) disable iff (reset)
        (current_mode && active) |-> (drive_ua >= 16'(pps_pkg::CUR_MIN_UA)
        && drive_ua <= 16'(pps_pkg::CUR_ZERO_UA + pps_pkg::CUR_SPAN_UA)))
        else $error("active current outside 4 to 20 mA");

    AST_CUR_CENTER: assert property (@(posedge sys_clk) disable iff (reset)
        (current_mode && active && valve_out == 32'sd0) |->
        (drive_ua == 16'(pps_pkg::CUR_ZERO_UA)))
        else $error("zero output not at 12 mA");

    AST_VOLT_POL: assert property (@(posedge sys_clk) disable iff (reset)
        (sample_en && cfg.out_sel == pps_pkg::PPS_VOLT_INVERT) |=>
        (32'(drive_mv) == -valve_out))
        else $error("inverted voltage polarity wrong");

    AST_RAMP_RISE: assert property (@(posedge sys_clk) disable iff (reset)
        (sample_en && run) |=> (ramp_acc - $past(ramp_acc) <= $past(step_up)))
        else $error("ramp rose faster than rise time");

    AST_INT_GATE: assert property (@(posedge sys_clk) disable iff (reset)
        (sample_en && run && ti != 32'sd0 && fb_pct <= i_thr) |=> $stable(integ))
        else $error("integrator moved below activation threshold");

    AST_INT_OFF: assert property (@(posedge sys_clk) disable iff (reset)
        (sample_en && ti == 32'sd0) |=> (integ == 32'sd0))
        else $error("integrator active with zero integral time");

    AST_KNEE: assert property (@(posedge sys_clk) disable iff (reset)
        (trig != 32'sd0 && u_mag < trig) |->
        (mag_a <= trig + 32'(cfg.adapt_a.deadband_min)))
        else $error("deadband curve above knee below threshold");

    AST_LIMIT_B: assert property (@(posedge sys_clk) disable iff (reset)
        (sample_en && run && cfg.trigger == 16'h0000 && cfg.zero_offset == 16'sh0000 &&
        cfg.adapt_b.deadband_min == 16'h0000 &&
        cfg.adapt_b.scale_max == 16'(pps_pkg::FULL_SCALE) &&
        cfg.cylinder_area_ratio > 16'(pps_pkg::RATIO_ONE)) |=>
        (64'(valve_out) * 64'($past(ratio)) >=
        -(64'(pps_pkg::FULL_SCALE) * 64'(pps_pkg::RATIO_ONE))))
        else $error("direction force limit exceeded");

    AST_RAMP_FALL: assert property (@(posedge sys_clk) disable iff (reset)
        (sample_en && run) |=> ($past(ramp_acc) - ramp_acc <= $past(step_dn)))
        else $error("ramp fell faster than fall time");

    AST_OFF_ZERO: assert property (@(posedge sys_clk) disable iff (reset)
        (sample_en && !run) |=>
        (valve_out == 32'sd0 && drive_mv == 16'sh0000 && !active))
        else $error("disabled path still drives the valve");

    AST_DFILT_LAG: assert property (@(posedge sys_clk) disable iff (reset)
        (sample_en && run && d_raw >= 64'(dfilt)) |=>
        (dfilt >= $past(dfilt) && 64'(dfilt) <= $past(d_raw)))
        else $error("derivative filter overshot its input");

    AST_ZERO_CORR: assert property (@(posedge sys_clk) disable iff (reset)
        (sample_en && run && u_pid == 32'sd0) |=>
        (valve_out == 32'($past(cfg.zero_offset))))
        else $error("zero correction not applied to idle output");

    AST_MODE_FLAG: assert property (@(posedge sys_clk) disable iff (reset)
        sample_en |=> (current_mode == ($past(cfg.out_sel) == pps_pkg::PPS_CUR_NORMAL ||
        $past(cfg.out_sel) == pps_pkg::PPS_CUR_INVERT)))
        else $error("current mode flag does not follow output selection");

endmodule

// file: pps_pressure_ctrl_bench.sv
// Self-checking bench for the pressure control path with a valve and sensor model.
// Assumes a short sample divider of 16 clocks and strobed outputs.
module pps_pressure_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    pps_pkg::pps_cfg_t cfg;
    pps_pkg::pps_pid_set_t set1, set2;
    logic pid_set_select = 1'b0;
    logic enable_pin = 1'b1;
    logic fault = 1'b0;
    logic signed [31:0] demand = 32'h0;
    logic signed [31:0] press = 32'h0;
    logic signed [31:0] fb_mbar, valve_out, ramp_cmd;
    logic signed [15:0] drive_mv;
    logic [15:0] drive_ua;
    logic current_mode, active, valve_on;
    int fails = 0;
    int samples_checked = 0;
    int cycles = 0;
    pps_pkg::pps_out_sel_t sels [4] = '{pps_pkg::PPS_VOLT_NORMAL, pps_pkg::PPS_VOLT_INVERT,
        pps_pkg::PPS_CUR_NORMAL, pps_pkg::PPS_CUR_INVERT};
    logic [31:0] exp_mv [4] = '{32'h7d0, -32'sh7d0, 32'h0, 32'h0};
    logic [31:0] exp_ua [4] = '{32'h0, 32'h0, 32'h3520, 32'h28a0};

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, device and far side
    always #4 sys_clk = ~sys_clk;
    pps_pressure_ctrl #(.SAMPLE_CYCLES(16)) u_dut (.sys_clk(sys_clk), .reset(reset), .cfg(cfg),
        .pid_set_1(set1), .pid_set_2(set2), .pid_set_select(pid_set_select),
        .enable_pin(enable_pin), .fault(fault), .pressure_demand(demand),
        .pressure_feedback_mbar(fb_mbar), .drive_mv(drive_mv), .drive_ua(drive_ua),
        .current_mode(current_mode), .active(active), .valve_out(valve_out),
        .ramp_cmd(ramp_cmd));
    pps_valve_model u_valve (.sys_clk(sys_clk), .current_mode(current_mode),
        .drive_ua(drive_ua), .press_mbar(press), .pressure_feedback_mbar(fb_mbar),
        .valve_on(valve_on));

    ////////////////////////////////////////////////////////////////////////////////
    // Compare, verdict and hang guard
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic summarize();
        if (fails == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            summarize();
        end
    end

    // Apply gain, demand and pressure, then let ten samples pass
    task automatic step(input logic [15:0] kp, input logic signed [31:0] dem,
                        input logic signed [31:0] pr);
        @(posedge sys_clk);
        set1.gain_p <= kp;
        demand <= dem;
        press <= pr;
        repeat (160) @(posedge sys_clk);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Test sequence
    initial
    begin
        cfg = '{16'h64, 16'h3e8, 32'sh0, 32'h1, 32'h1, '{16'h0, 16'h2710}, '{16'h0, 16'h2710},
            16'h0, 16'sh0, pps_pkg::PPS_VOLT_NORMAL};
        set1 = '{16'h0, 16'h0, 16'h0, 16'h5, 16'h0};
        set2 = '{16'hc8, 16'h0, 16'h0, 16'h5, 16'h0};
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        step(16'h64, 32'sh7d0, 32'sh0);
        check("valve_out", valve_out, 32'h7d0);
        check("drive_mv", 32'(drive_mv), 32'h7d0);
        step(16'h12c, 32'sh2710, 32'sh0);
        check("valve_out", valve_out, 32'h2710);
        // Feedback scaling and offset
        step(16'h64, 32'sh0, 32'sh7530);
        check("valve_out", valve_out, -32'shbb8);
        cfg.feedback_offset <= -32'sh2710;
        step(16'h64, 32'sh0, 32'sh7530);
        check("valve_out", valve_out, -32'sh7d0);
        cfg.feedback_offset <= 32'sh0;
        // Area ratio limits per direction
        cfg.cylinder_area_ratio <= 16'h7d0;
        step(16'h12c, 32'sh0, 32'sh7530);
        check("valve_out", valve_out, -32'sh1388);
        step(16'h12c, 32'sh2710, 32'sh0);
        check("valve_out", valve_out, 32'h2710);
        cfg.cylinder_area_ratio <= 16'h1f4;
        step(16'h12c, 32'sh2710, 32'sh0);
        check("valve_out", valve_out, 32'h1388);
        cfg.cylinder_area_ratio <= 16'h3e8;
        // Second parameter set
        pid_set_select <= 1'b1;
        step(16'h64, 32'sh3e8, 32'sh0);
        check("valve_out", valve_out, 32'h7d0);
        pid_set_select <= 1'b0;
        // Kinked deadband curve per direction
        cfg.trigger <= 16'h3e8;
        cfg.adapt_a.deadband_min <= 16'h3e8;
        cfg.adapt_b <= '{16'h3e8, 16'h1388};
        step(16'h64, 32'sh1f4, 32'sh0);
        check("valve_out", valve_out, 32'h3e8);
        step(16'h64, 32'sh7d0, 32'sh0);
        check("valve_out", valve_out, 32'hb48);
        step(16'h64, 32'sh0, 32'sh4e20);
        check("valve_out", valve_out, -32'sh91d);
        cfg.trigger <= 16'h0;
        cfg.adapt_a.deadband_min <= 16'h0;
        cfg.adapt_b <= '{16'h0, 16'h2710};
        // Separate rise and fall ramps
        cfg.pressure_ramp_time_up <= 32'h927c0;
        cfg.pressure_ramp_time_down <= 32'h927c0;
        step(16'h0, 32'sh1388, 32'sh0);
        check("ramp_slow_up", 32'(ramp_cmd < 32'sh1388), 32'h1);
        cfg.pressure_ramp_time_up <= 32'h1;
        step(16'h0, 32'sh1388, 32'sh0);
        check("ramp_cmd", ramp_cmd, 32'h1388);
        step(16'h0, 32'sh0, 32'sh0);
        check("ramp_slow_down", 32'(ramp_cmd > 32'sh3e8), 32'h1);
        cfg.pressure_ramp_time_down <= 32'h1;
        step(16'h0, 32'sh0, 32'sh0);
        check("ramp_cmd", ramp_cmd, 32'h0);
        // Filtered derivative lags a demand step, then a fault clears it
        set1.derivative_time <= 16'h4b0;
        set1.derivative_filter_time <= 16'h3e8;
        step(16'h64, 32'sh3e8, 32'sh0);
        check("d_lag_low", 32'(valve_out > 32'sh7d0), 32'h1);
        check("d_lag_high", 32'(valve_out <= 32'sh88c), 32'h1);
        fault <= 1'b1;
        set1.derivative_time <= 16'h0;
        step(16'h0, 32'sh0, 32'sh0);
        check("active", 32'(active), 32'h0);
        fault <= 1'b0;
        // Integrator gate and disable
        set1.integral_time <= 16'h3e8;
        set1.integrator_activation_threshold <= 16'h1388;
        step(16'h64, 32'sh3e8, 32'sh0);
        check("valve_out", valve_out, 32'h3e8);
        set1.integrator_activation_threshold <= 16'h32;
        step(16'h64, 32'sh44c, 32'sh3e8);
        check("integ_grows", 32'(valve_out > 32'sh3e8), 32'h1);
        enable_pin <= 1'b0;
        step(16'h64, 32'sh44c, 32'sh3e8);
        check("active", 32'(active), 32'h0);
        check("valve_out", valve_out, 32'h0);
        enable_pin <= 1'b1;
        set1.integral_time <= 16'h0;
        step(16'h64, 32'sh44c, 32'sh3e8);
        check("valve_out", valve_out, 32'h3e8);
        // Output selections with zero correction
        cfg.zero_offset <= 16'sh7d0;
        for (int i = 0; i < 4; i++)
        begin
            cfg.out_sel <= sels[i];
            step(16'h0, 32'sh0, 32'sh0);
            check("valve_out", valve_out, 32'h7d0);
            check("drive_mv", 32'(drive_mv), exp_mv[i]);
            check("drive_ua", 32'(drive_ua), exp_ua[i]);
            check("current_mode", 32'(current_mode), 32'(i / 2));
        end
        // Fault in current mode drops below the live zero
        fault <= 1'b1;
        step(16'h0, 32'sh0, 32'sh0);
        check("drive_ua", 32'(drive_ua), 32'h0);
        check("valve_on", 32'(valve_on), 32'h0);
        fault <= 1'b0;
        step(16'h0, 32'sh0, 32'sh0);
        check("valve_on", 32'(valve_on), 32'h1);
        // Zero output sits at the current centre point
        cfg.zero_offset <= 16'sh0;
        step(16'h0, 32'sh0, 32'sh0);
        check("drive_ua", 32'(drive_ua), 32'h2ee0);
        summarize();
    end
endmodule

// file: pps_valve_model.sv
// Far side model: pressure sensor feeding back mbar and a current-watching valve.
// Assumes the bench sets the hydraulic pressure and the device drives the valve.
module pps_valve_model (
    // Clock
    input wire logic sys_clk,
    // Valve drive from the device
    input wire logic current_mode,
    input wire logic [15:0] drive_ua,
    // Hydraulic pressure set by the bench
    input wire logic signed [31:0] press_mbar,
    // Sensor word and valve state
    output logic signed [31:0] pressure_feedback_mbar,
    output logic valve_on
);
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////////////////////////////////////////////////////
    // Sensor word changes just after the clock edge
    initial pressure_feedback_mbar = 32'h0;
    always @(posedge sys_clk)
    begin
        pressure_feedback_mbar <= press_mbar;
    end

    // Valve drops out on a current below the live-zero floor
    assign valve_on = !(current_mode && (drive_ua < 16'(pps_pkg::CUR_MIN_UA)));
endmodule
